// File: include/ebst_pkg.sv
// What this block does
// - device enters reset after reset pin is low three machine cycles
// - serial transmit may keep shifting up to four machine cycles after reset applied
// - address latch strobe drives external latch capture of low address byte
// - address latch strobe pulses at one sixth of oscillator rate
// - each external data access cycle omits exactly one address latch pulse
// - address latch strobe stays high throughout reset
// - program fetch strobe is active low, used for external code execution
// - external code execution asserts program fetch strobe twice per machine cycle
// - each external data access skips two program fetch strobe assertions
// - program fetch strobe stays high throughout reset
// - port 3 carries serial, interrupt, timer inputs and data write/read strobes
// - port 4 is 8-bit quasi-bidirectional; latch 1 releases pin for input
// - bus select high moves fetch strobe onto alternate program store strobe
package ebst_pkg;

	// ************************************************************
	// widths and timing
	// ************************************************************
	localparam int PORT_W = 8;
	localparam int PH_W = 4;
	localparam int CNT_W = 6;
	localparam int OSC_PER_MC = 12;
	localparam int RESET_MC = 3;
	localparam int TAIL_MC = 4;
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(OSC_PER_MC - 1);
	localparam logic [CNT_W-1:0] RESET_CLKS = CNT_W'(RESET_MC * OSC_PER_MC);
	localparam logic [CNT_W-1:0] TAIL_CLKS = CNT_W'(TAIL_MC * OSC_PER_MC);

	// ************************************************************
	// strobe slots, phase of first cycle and length
	// ************************************************************
	localparam logic [PH_W-1:0] ALE_A_FIRST = 4'h1;
	localparam logic [PH_W-1:0] ALE_B_FIRST = 4'h7;
	localparam logic [PH_W-1:0] ALE_LEN = 4'h2;
	localparam logic [PH_W-1:0] FETCH_A_FIRST = 4'h3;
	localparam logic [PH_W-1:0] FETCH_B_FIRST = 4'h9;
	localparam logic [PH_W-1:0] FETCH_LEN = 4'h3;
	localparam logic [PH_W-1:0] DSTB_FIRST = 4'h3;
	localparam logic [PH_W-1:0] DSTB_LEN = 4'h8;

	// ************************************************************
	// port layout and reset values
	// ************************************************************
	localparam logic [PORT_W-1:0] PORT_RST = 8'hff;
	localparam int P3_SERIAL_RX = 0;
	localparam int P3_SERIAL_TX = 1;
	localparam int P3_EXT_INT_ZERO = 2;
	localparam int P3_EXT_INT_ONE = 3;
	localparam int P3_TIMER_ZERO = 4;
	localparam int P3_TIMER_ONE = 5;
	localparam int P3_WRITE_STB = 6;
	localparam int P3_READ_STB = 7;

	// ************************************************************
	// pin filter vector layout
	// ************************************************************
	localparam int SY_P3_LSB = 0;
	localparam int SY_P4_LSB = 8;
	localparam int SY_RST = 16;
	localparam int SY_BUS_SEL = 17;
	localparam int SYNC_W = 18;
	localparam logic [SYNC_W-1:0] SYNC_RST = 18'h3_ffff;

	// ************************************************************
	// machine cycle kinds
	// ************************************************************
	typedef enum logic [1:0]
	{
		MC_RESET = 2'h0,
		MC_CODE = 2'h1,
		MC_DATA = 2'h3
	} ebst_mc_t;

endpackage

// File: include/ebst_sync_if.sv
`timescale 1ns/1ps
// ************************************************************
// raw pin levels in, filtered levels out
// ************************************************************
interface ebst_sync_if #(parameter int W = 18);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// File: logic/ebst_pin_filter.sv
`timescale 1ns/1ps
module ebst_pin_filter #(
	parameter int W = 18,
	parameter logic [W-1:0] RESET_VAL = '1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// pins
	ebst_sync_if.filt pins
);
	import ebst_pkg::*;

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] clean_q;

	// ************************************************************
	// three stages; first stage feeds only the second
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end
		else
		begin
			s1_q <= pins.raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit moves only once stages two and three agree
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			clean_q <= RESET_VAL;
		else
			clean_q <= (s2_q & s3_q) | (clean_q & (s2_q ^ s3_q));
	end

	assign pins.clean = clean_q;

endmodule

// File: logic/ebst_top.sv
`timescale 1ns/1ps
module ebst_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// reset and fetch bus select pins
	input wire logic reset_pin_n_in,
	input wire logic fetch_bus_select_in,
	// core requests, same clock
	input wire logic core_ext_code_in,
	input wire logic core_data_req_in,
	input wire logic core_data_write_in,
	input wire logic core_p3_wr_in,
	input wire logic [ebst_pkg::PORT_W-1:0] core_p3_data_in,
	input wire logic core_p4_wr_in,
	input wire logic [ebst_pkg::PORT_W-1:0] core_p4_data_in,
	input wire logic verify_mode_in,
	input wire logic serial_tx_data_in,
	// core status
	output logic core_mc_end_out,
	output logic device_reset_out,
	output logic serial_tx_allowed_out,
	output logic data_cycle_out,
	// bus strobes
	output logic address_latch_strobe_out,
	output logic program_fetch_strobe_n_out,
	output logic alternate_program_store_strobe_n_out,
	output logic fetch_on_alt_ports_out,
	// port 3 pins
	input wire logic [ebst_pkg::PORT_W-1:0] port3_pin_in,
	output logic [ebst_pkg::PORT_W-1:0] port3_pin_out,
	output logic [ebst_pkg::PORT_W-1:0] port3_pin_oe_n_out,
	// port 3 alternate inputs
	output logic serial_rx_data_out,
	output logic external_interrupt_zero_out,
	output logic external_interrupt_one_out,
	output logic timer_zero_input_out,
	output logic timer_one_input_out,
	// port 4 pins
	input wire logic [ebst_pkg::PORT_W-1:0] port4_pin_in,
	output logic [ebst_pkg::PORT_W-1:0] port4_pin_out,
	output logic [ebst_pkg::PORT_W-1:0] port4_pin_oe_n_out,
	output logic [ebst_pkg::PORT_W-1:0] port4_read_out,
	output logic [ebst_pkg::PORT_W-1:0] verify_addr_low_out
);
	import ebst_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	ebst_sync_if #(.W(SYNC_W)) sync_bus ();

	logic pin_low;
	logic bus_sel_clean;
	logic [PORT_W-1:0] p3_clean;
	logic [PORT_W-1:0] p4_clean;
	logic [CNT_W-1:0] rst_cnt_q;
	logic [CNT_W-1:0] tail_cnt_q;
	logic device_reset_q;
	logic tx_allowed;
	logic serial_txd_q;
	logic [PH_W-1:0] phase_q;
	ebst_mc_t mc_q;
	logic mc_start;
	logic ext_q;
	logic write_q;
	logic bus_sel_q;
	logic ale_d;
	logic fetch_n_d;
	logic rd_n_d;
	logic wr_n_d;
	logic ale_q;
	logic fetch_n_q;
	logic alt_fetch_n_q;
	logic alt_ports_q;
	logic [PORT_W-1:0] p3_latch_q;
	logic [PORT_W-1:0] p4_latch_q;
	logic [PORT_W-1:0] p3_val_d;
	logic [PORT_W-1:0] p3_val_q;
	logic [PORT_W-1:0] p4_val_q;
	logic [PORT_W-1:0] verify_addr_q;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic in_slot(input logic [PH_W-1:0] ph, input logic [PH_W-1:0] first,
		input logic [PH_W-1:0] len);
		in_slot = (ph >= first) && (ph < first + len);
	endfunction

	// ************************************************************
	// pin filtering
	// ************************************************************
	assign sync_bus.raw = {fetch_bus_select_in, reset_pin_n_in, port4_pin_in, port3_pin_in};

	ebst_pin_filter #(
		.W(SYNC_W),
		.RESET_VAL(SYNC_RST)
	) u_filter (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.pins(sync_bus)
	);

	assign pin_low = ~sync_bus.clean[SY_RST];
	assign bus_sel_clean = sync_bus.clean[SY_BUS_SEL];
	assign p3_clean = sync_bus.clean[SY_P3_LSB +: PORT_W];
	assign p4_clean = sync_bus.clean[SY_P4_LSB +: PORT_W];

	// ************************************************************
	// reset pin recognition
	// ************************************************************
	// counts oscillator periods so a glitch shorter than three machine cycles never resets
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rst_cnt_q <= '0;
			device_reset_q <= 1'b1;
		end
		else if (pin_low)
		begin
			if (rst_cnt_q == RESET_CLKS - 6'h1)
				device_reset_q <= 1'b1;
			else
				rst_cnt_q <= rst_cnt_q + 6'h1;
		end
		else
		begin
			rst_cnt_q <= '0;
			device_reset_q <= 1'b0;
		end
	end

	// ************************************************************
	// serial transmit tail
	// ************************************************************
	// starts at the first low sample, not at recognition, so the tail is bounded
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || !pin_low)
			tail_cnt_q <= '0;
		else if (tail_cnt_q != TAIL_CLKS)
			tail_cnt_q <= tail_cnt_q + 6'h1;
	end

	assign tx_allowed = (tail_cnt_q != TAIL_CLKS);

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			serial_txd_q <= 1'b1;
		else if (tx_allowed)
			serial_txd_q <= serial_tx_data_in;
		else
			serial_txd_q <= 1'b1;
	end

	// ************************************************************
	// machine cycle sequencing
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || device_reset_q)
			phase_q <= '0;
		else if (phase_q == PH_LAST)
			phase_q <= '0;
		else
			phase_q <= phase_q + 4'h1;
	end

	assign mc_start = !device_reset_q && ((phase_q == PH_LAST) || (mc_q == MC_RESET));

	// kind of cycle, code source and fetch path are frozen for a whole machine cycle
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || device_reset_q)
		begin
			mc_q <= MC_RESET;
			ext_q <= 1'b0;
			write_q <= 1'b0;
			bus_sel_q <= 1'b0;
		end
		else if (mc_start)
		begin
			mc_q <= core_data_req_in ? MC_DATA : MC_CODE;
			ext_q <= core_ext_code_in;
			write_q <= core_data_write_in;
			bus_sel_q <= bus_sel_clean;
		end
	end

	// ************************************************************
	// strobe decode
	// ************************************************************
	always_comb
	begin
		ale_d = 1'b0;
		fetch_n_d = 1'b1;
		rd_n_d = 1'b1;
		wr_n_d = 1'b1;
		// recognition overrides at once; the cycle state itself clears one clock later
		case (device_reset_q ? MC_RESET : mc_q)
			MC_RESET:
			begin
				ale_d = 1'b1;
				fetch_n_d = 1'b1;
			end
			MC_CODE:
			begin
				ale_d = in_slot(phase_q, ALE_A_FIRST, ALE_LEN) ||
					in_slot(phase_q, ALE_B_FIRST, ALE_LEN);
				fetch_n_d = !(ext_q && (in_slot(phase_q, FETCH_A_FIRST, FETCH_LEN) ||
					in_slot(phase_q, FETCH_B_FIRST, FETCH_LEN)));
			end
			MC_DATA:
			begin
				// second slot dropped; the first latches the data address
				ale_d = in_slot(phase_q, ALE_A_FIRST, ALE_LEN);
				fetch_n_d = 1'b1;
				rd_n_d = !(!write_q && in_slot(phase_q, DSTB_FIRST, DSTB_LEN));
				wr_n_d = !(write_q && in_slot(phase_q, DSTB_FIRST, DSTB_LEN));
			end
			default:
			begin
				ale_d = 1'b1;
				fetch_n_d = 1'b1;
			end
		endcase
	end

	// ************************************************************
	// strobe outputs
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			ale_q <= 1'b1;
			fetch_n_q <= 1'b1;
			alt_fetch_n_q <= 1'b1;
			alt_ports_q <= 1'b0;
		end
		else
		begin
			ale_q <= ale_d;
			fetch_n_q <= bus_sel_q ? 1'b1 : fetch_n_d;
			alt_fetch_n_q <= bus_sel_q ? fetch_n_d : 1'b1;
			alt_ports_q <= bus_sel_q;
		end
	end

	// ************************************************************
	// port latches
	// ************************************************************
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || device_reset_q)
			p3_latch_q <= PORT_RST;
		else if (core_p3_wr_in)
			p3_latch_q <= core_p3_data_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || device_reset_q)
			p4_latch_q <= PORT_RST;
		else if (core_p4_wr_in)
			p4_latch_q <= core_p4_data_in;
	end

	// ************************************************************
	// port 3 alternate outputs
	// ************************************************************
	// a latch bit at 0 still overrides its alternate output, as on any quasi port
	always_comb
	begin
		p3_val_d = p3_latch_q;
		p3_val_d[P3_SERIAL_TX] = p3_latch_q[P3_SERIAL_TX] & serial_txd_q;
		p3_val_d[P3_WRITE_STB] = p3_latch_q[P3_WRITE_STB] & wr_n_d;
		p3_val_d[P3_READ_STB] = p3_latch_q[P3_READ_STB] & rd_n_d;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			p3_val_q <= PORT_RST;
		else
			p3_val_q <= p3_val_d;
	end

	// ************************************************************
	// port 4 and program verify
	// ************************************************************
	// in verify the pins are released so the programmer can drive them
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			p4_val_q <= PORT_RST;
		else if (verify_mode_in)
			p4_val_q <= PORT_RST;
		else
			p4_val_q <= p4_latch_q;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			verify_addr_q <= '0;
		else if (verify_mode_in)
			verify_addr_q <= p4_clean;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign core_mc_end_out = mc_start;
	assign device_reset_out = device_reset_q;
	assign serial_tx_allowed_out = tx_allowed;
	assign data_cycle_out = (mc_q == MC_DATA);
	assign address_latch_strobe_out = ale_q;
	assign program_fetch_strobe_n_out = fetch_n_q;
	assign alternate_program_store_strobe_n_out = alt_fetch_n_q;
	assign fetch_on_alt_ports_out = alt_ports_q;
	// drive low only; a 1 releases the pin to the weak pullup
	assign port3_pin_out = p3_val_q;
	assign port3_pin_oe_n_out = p3_val_q;
	assign port4_pin_out = p4_val_q;
	assign port4_pin_oe_n_out = p4_val_q;
	assign serial_rx_data_out = p3_clean[P3_SERIAL_RX];
	assign external_interrupt_zero_out = p3_clean[P3_EXT_INT_ZERO];
	assign external_interrupt_one_out = p3_clean[P3_EXT_INT_ONE];
	assign timer_zero_input_out = p3_clean[P3_TIMER_ZERO];
	assign timer_one_input_out = p3_clean[P3_TIMER_ONE];
	assign port4_read_out = p4_clean;
	assign verify_addr_low_out = verify_addr_q;

endmodule

// File: tb/ebst_ext_mem.sv
`timescale 1ns/1ps
module ebst_ext_mem
	import ebst_pkg::*;
#(
	parameter logic [7:0] VERIFY_ADDR = 8'h00
) (
	// clock and strobes
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic verify_in,
	// pins
	input wire logic [ebst_pkg::PORT_W-1:0] drive3_in,
	input wire logic [ebst_pkg::PORT_W-1:0] p3_oe_n_in,
	input wire logic [ebst_pkg::PORT_W-1:0] p4_oe_n_in,
	output logic [ebst_pkg::PORT_W-1:0] p3_pin_out,
	output logic [ebst_pkg::PORT_W-1:0] p4_pin_out,
	// latch captures
	output int latch_cnt_out
);
	logic ale_q;
	// released pins sit at the pullup level unless pulled low
	assign p3_pin_out = drive3_in & p3_oe_n_in;
	assign p4_pin_out = verify_in ? VERIFY_ADDR & p4_oe_n_in : p4_oe_n_in;
	always_ff @(posedge clk_in)
	begin
		ale_q <= ale_in;
		if (ale_q && !ale_in)
			latch_cnt_out <= latch_cnt_out + 1;
	end
endmodule

// File: tb/ebst_chk.sv
`timescale 1ns/1ps
module ebst_chk (
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// watched ports
	input wire logic reset_pin_n_in,
	input wire logic verify_mode_in,
	input wire logic device_reset_out,
	input wire logic serial_tx_allowed_out,
	input wire logic address_latch_strobe_out,
	input wire logic program_fetch_strobe_n_out,
	input wire logic alternate_program_store_strobe_n_out,
	input wire logic fetch_on_alt_ports_out,
	input wire logic [ebst_pkg::PORT_W-1:0] port3_pin_out,
	input wire logic [ebst_pkg::PORT_W-1:0] port4_pin_oe_n_out
);
	import ebst_pkg::*;
	logic ale_q, fs_q;
	logic [3:0] gap_q, fcnt_q;
	logic [5:0] low_q;
	wire ale = address_latch_strobe_out;
	wire fs = program_fetch_strobe_n_out & alternate_program_store_strobe_n_out;
	wire rise = ale & ~ale_q;
	// ********************
	// helper counters
	// ********************
	always_ff @(posedge clk_in)
	begin
		ale_q <= ale;
		fs_q <= fs;
	end
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || device_reset_out)
			gap_q <= '0;
		else if (rise)
			gap_q <= 4'h1;
		else if (gap_q != 4'h0 && gap_q != 4'hf)
			gap_q <= gap_q + 4'h1;
	end
	// fetch falls since the last latch pulse
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in || rise)
			fcnt_q <= '0;
		else if (fs_q && !fs && fcnt_q != 4'hf)
			fcnt_q <= fcnt_q + 4'h1;
	end
	always_ff @(posedge clk_in)
	begin
		if (reset_pin_n_in)
			low_q <= '0;
		else if (low_q != 6'h3f)
			low_q <= low_q + 6'h1;
	end
	// ********************
	// assertions
	// ********************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	a_ale_rst_high: assert property (device_reset_out && $past(device_reset_out) |-> ale)
		else $error("latch strobe low in reset");
	a_fetch_rst_high: assert property (device_reset_out && $past(device_reset_out) |-> fs)
		else $error("fetch strobe low in reset");
	a_ale_width: assert property (disable iff (sys_rst_in || device_reset_out)
		$rose(ale) |=> ale ##1 !ale) else $error("latch strobe width");
	a_ale_gap: assert property (rise && gap_q != 4'h0 |-> gap_q == 4'h6 || gap_q == 4'hc)
		else $error("latch strobe spacing");
	a_fetch_once: assert property (rise && gap_q == 4'h6 |-> fcnt_q <= 4'h1)
		else $error("fetch strobes per slot");
	a_data_skip: assert property (rise && gap_q == 4'hc |-> fcnt_q == 4'h0)
		else $error("fetch strobe in data cycle");
	a_fetch_width: assert property (disable iff (sys_rst_in || device_reset_out)
		$fell(fs) |-> (!fs) [*3] ##1 fs) else $error("fetch strobe width");
	a_sel_primary: assert property (!fetch_on_alt_ports_out && !$past(fetch_on_alt_ports_out)
		|-> alternate_program_store_strobe_n_out) else $error("alternate strobe used");
	a_sel_alt: assert property (fetch_on_alt_ports_out && $past(fetch_on_alt_ports_out)
		|-> program_fetch_strobe_n_out) else $error("primary strobe used");
	a_rd_width: assert property (disable iff (sys_rst_in || device_reset_out)
		$fell(port3_pin_out[P3_READ_STB]) |-> (!port3_pin_out[P3_READ_STB]) [*8]
		##1 port3_pin_out[P3_READ_STB]) else $error("read strobe width");
	a_rst_entry: assert property ($rose(device_reset_out) |-> low_q >= 6'h24 && low_q <= 6'h2a)
		else $error("reset entry delay");
	a_tail_end: assert property ($fell(serial_tx_allowed_out)
		|-> device_reset_out && low_q >= 6'h30 && low_q <= 6'h36) else $error("tail length");
	a_p4_verify: assert property (verify_mode_in && $past(verify_mode_in)
		|-> port4_pin_oe_n_out == 8'hff) else $error("port 4 driven in verify");
endmodule
bind ebst_top ebst_chk u_chk (.clk_in, .sys_rst_in, .reset_pin_n_in, .verify_mode_in,
	.device_reset_out, .serial_tx_allowed_out, .address_latch_strobe_out,
	.program_fetch_strobe_n_out, .alternate_program_store_strobe_n_out,
	.fetch_on_alt_ports_out, .port3_pin_out, .port4_pin_oe_n_out);

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import ebst_pkg::*;
	localparam logic [7:0] VERIFY_ADDR = 8'h5a;
	logic clk_in, sys_rst_in, reset_pin_n_in, fetch_bus_select_in, core_ext_code_in;
	logic core_data_req_in, core_data_write_in, core_p3_wr_in, core_p4_wr_in;
	logic verify_mode_in, serial_tx_data_in, core_mc_end_out, device_reset_out;
	logic serial_tx_allowed_out, data_cycle_out, address_latch_strobe_out;
	logic program_fetch_strobe_n_out, alternate_program_store_strobe_n_out;
	logic fetch_on_alt_ports_out, serial_rx_data_out, external_interrupt_zero_out;
	logic external_interrupt_one_out, timer_zero_input_out, timer_one_input_out;
	logic [7:0] core_p3_data_in, core_p4_data_in, port3_pin_in, port3_pin_out;
	logic [7:0] port3_pin_oe_n_out, port4_pin_in, port4_pin_out, port4_pin_oe_n_out;
	logic [7:0] port4_read_out, verify_addr_low_out, drive3;
	int fail_count, cmp_count, cycles, latch_cnt, n;
	// inputs: ext code, data req, write, select; falls in 48 clk: ale, fetch, alt, wr, rd
	logic [23:0] rows [5] = '{24'h88_8000, 24'h98_0800, 24'h08_0000, 24'hc4_0004, 24'hf4_0040};
	wire [4:0] strobes = {address_latch_strobe_out, program_fetch_strobe_n_out,
		alternate_program_store_strobe_n_out, port3_pin_out[6], port3_pin_out[7]};
	ebst_top DUT (.clk_in, .sys_rst_in, .reset_pin_n_in, .fetch_bus_select_in,
		.core_ext_code_in, .core_data_req_in, .core_data_write_in, .core_p3_wr_in,
		.core_p3_data_in, .core_p4_wr_in, .core_p4_data_in, .verify_mode_in,
		.serial_tx_data_in, .core_mc_end_out, .device_reset_out, .serial_tx_allowed_out,
		.data_cycle_out, .address_latch_strobe_out, .program_fetch_strobe_n_out,
		.alternate_program_store_strobe_n_out, .fetch_on_alt_ports_out, .port3_pin_in,
		.port3_pin_out, .port3_pin_oe_n_out, .serial_rx_data_out,
		.external_interrupt_zero_out, .external_interrupt_one_out, .timer_zero_input_out,
		.timer_one_input_out, .port4_pin_in, .port4_pin_out, .port4_pin_oe_n_out,
		.port4_read_out, .verify_addr_low_out);
	ebst_ext_mem #(.VERIFY_ADDR(VERIFY_ADDR)) u_mem (.clk_in, .ale_in(address_latch_strobe_out),
		.verify_in(verify_mode_in), .drive3_in(drive3), .p3_oe_n_in(port3_pin_oe_n_out),
		.p4_oe_n_in(port4_pin_oe_n_out), .p3_pin_out(port3_pin_in),
		.p4_pin_out(port4_pin_in), .latch_cnt_out(latch_cnt));
	// ********************
	// helpers
	// ********************
	task automatic complete_run;
		if (fail_count == 0 && cmp_count != 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [19:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	// counts falling edges over 48 clk, four whole machine cycles
	task automatic measure(input logic [19:0] exp, input logic held);
		logic [4:0] prev;
		logic [19:0] got;
		int lat0, ends, dat, alt;
		got = '0;
		ends = 0;
		dat = 0;
		alt = 0;
		lat0 = latch_cnt;
		prev = strobes;
		repeat (48)
		begin
			tick(1);
			for (int i = 0; i < 5; i++)
				if (prev[i] && !strobes[i])
					got[4*i+:4] = got[4*i+:4] + 4'h1;
			prev = strobes;
			ends += core_mc_end_out;
			dat += data_cycle_out;
			alt += fetch_on_alt_ports_out;
		end
		check("strobe falls", got, exp);
		check("latch captures", 20'(latch_cnt - lat0), 20'(exp[19:16]));
		check("cycle ends", 20'(ends), held ? 20'h0 : 20'h4);
		check("data cycles", 20'(dat), (core_data_req_in && !held) ? 20'h30 : 20'h0);
		check("alt ports", 20'(alt), (fetch_bus_select_in && !held) ? 20'h30 : 20'h0);
	endtask
	initial
	begin
		clk_in = 0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			complete_run();
		end
	end
	// ********************
	// main sequence
	// ********************
	initial
	begin
		{sys_rst_in, reset_pin_n_in, serial_tx_data_in, drive3} = {3'h7, 8'hff};
		{fetch_bus_select_in, core_ext_code_in, core_data_req_in, core_data_write_in} = 4'h0;
		{core_p3_wr_in, core_p4_wr_in, verify_mode_in} = 3'h0;
		{core_p3_data_in, core_p4_data_in} = 16'hffff;
		tick(3);
		check("reset strobes", 20'(strobes[4:2]), 20'h7);
		check("reset port 4", 20'(port4_pin_oe_n_out), 20'(PORT_RST));
		sys_rst_in = 0;
		foreach (rows[r])
		begin
			{core_ext_code_in, core_data_req_in, core_data_write_in, fetch_bus_select_in} = rows[r][23:20];
			tick(36);
			measure(rows[r][19:0], 1'b0);
		end
		for (int i = 0; i < 2; i++)
		begin
			drive3 = i ? 8'hd5 : 8'hea;
			tick(6);
			check("port 3 inputs", 20'({timer_one_input_out, timer_zero_input_out,
				external_interrupt_one_out, external_interrupt_zero_out, serial_rx_data_out}),
				20'({drive3[5:2], drive3[0]}));
		end
		drive3 = 8'hff;
		{core_p4_wr_in, core_p4_data_in} = 9'h10f;
		tick(1);
		core_p4_wr_in = 0;
		tick(8);
		check("port 4 drive", 20'({port4_pin_out, port4_pin_oe_n_out}), 20'h0f0f);
		check("port 4 read", 20'(port4_read_out), 20'h0f);
		verify_mode_in = 1;
		tick(8);
		check("verify address", 20'(verify_addr_low_out), 20'(VERIFY_ADDR));
		check("port 4 released", 20'(port4_pin_oe_n_out), 20'hff);
		verify_mode_in = 0;
		{core_ext_code_in, core_data_req_in, fetch_bus_select_in} = 3'h4;
		tick(24);
		{reset_pin_n_in, serial_tx_data_in} = 2'h0;
		n = 0;
		while (device_reset_out !== 1'b1 && n < 60)
		begin
			tick(1);
			n++;
		end
		check("reset delay", 20'(n >= 36 && n <= 42), 20'h1);
		check("tail open", 20'({serial_tx_allowed_out, port3_pin_out[1]}), 20'h2);
		measure(20'h0, 1'b1);
		check("strobes held", 20'(strobes[4:2]), 20'h7);
		check("port 3 released", 20'(port3_pin_oe_n_out), 20'hff);
		check("tail closed", 20'({serial_tx_allowed_out, port3_pin_out[1]}), 20'h1);
		reset_pin_n_in = 1;
		tick(12);
		check("reset left", 20'(device_reset_out), 20'h0);
		complete_run();
	end
endmodule
